/* logic/rbbs_pkg.sv */
package rbbs_pkg;
    // oscillator clocks per machine cycle, 6 clock mode
    localparam logic [2:0] MC_LAST   = 3'h5;
    localparam logic [2:0] STB_PH_A  = 3'h1;
    localparam logic [2:0] STB_PH_B  = 3'h4;
    // machine cycle counts for reset and host entry
    localparam logic [4:0] RST_MC    = 5'h02;
    localparam logic [4:0] HOST_MC   = 5'h14;
    localparam logic [4:0] CNT_MAX   = 5'h1f;
    // register offsets
    localparam logic [1:0] CFG_OFS   = 2'h0;
    localparam logic [1:0] CMD_OFS   = 2'h1;
    localparam logic [1:0] STAT_OFS  = 2'h2;
    // field positions
    localparam int CFG_IAP_EN        = 6;
    localparam int CMD_PROG_LO       = 0;
    localparam int CMD_PROG_HI       = 1;
    localparam int CMD_ERASE         = 2;
    // reset values
    localparam logic [1:0] SC_UNPROG = 2'h3;
    localparam logic [1:0] FIELD_RST = 2'h0;
    localparam logic [7:0] DATA_ZERO = 8'h00;
    // host commands on the third port, taken on rise of bit 7
    localparam int HOST_STB_BIT      = 7;
    localparam logic [2:0] HCMD_LO   = 3'h1;
    localparam logic [2:0] HCMD_HI   = 3'h2;
    localparam logic [2:0] HCMD_ERA  = 3'h4;
    // synchroniser lanes
    localparam int IN_W   = 11;
    localparam int IX_RST = 0;
    localparam int IX_STB = 1;
    localparam int IX_EFS = 2;
    localparam int IX_TP  = 3;
    // idle pin levels: reset pin low, strobe, select, port pulled high
    localparam logic [10:0] IN_IDLE = 11'h7fe;

    typedef struct packed {
        logic por;
        logic wdt;
        logic bod;
        logic sw;
    } rbbs_rst_src_s;

    typedef struct packed {
        logic [1:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } rbbs_bus_s;
endpackage

/* logic/rbbs_top.sv */
`timescale 1ns/1ps
// Overview of operation
// - reset pin high two machine cycles resets
// - strobe fall, reset held >20 cycles: host
// - no strobe fall: leave reset to normal
// - fetch external only while select pin low
// - lock level 4 forces internal fetch
// - strobe idle high, else two pulses/cycle, one on data access
// - host control bits come from third port
// - block switch field loads after reset
// - startup bits programmed only by commands
// - programmed bit reads 0, unprogrammed 1
// - power-on/external: inverse; software: bit1 set
// - watchdog/brown-out: bit1 kept if high unprogrammed
// - software may change field bit 0
module rbbs_top (
    // clock, reset, enable
    input  wire logic                   clk_i,
    input  wire logic                   sys_rst_i,
    input  wire logic                   ce_i,
    // pins
    input  wire logic                   rst_pin_i,
    input  wire logic                   strobe_in_i,
    output logic                        strobe_o,
    output logic                        strobe_oe_o,
    input  wire logic                   ext_fetch_sel_i,
    input  wire logic [7:0]             third_port_i,
    // core side
    input  wire rbbs_pkg::rbbs_rst_src_s rst_src_i,
    input  wire logic                   sec_lvl4_i,
    input  wire logic                   ext_data_cyc_i,
    output logic                        core_rst_o,
    output logic                        host_mode_o,
    output logic                        ext_fetch_o,
    output logic [1:0]                  block_sel_o,
    // register port
    input  wire rbbs_pkg::rbbs_bus_s    bus_i,
    output logic [7:0]                  rdata_o
);
    logic [rbbs_pkg::IN_W-1:0] in_w;
    logic [rbbs_pkg::IN_W-1:0] s1_q;
    logic [rbbs_pkg::IN_W-1:0] s2_q;
    logic [rbbs_pkg::IN_W-1:0] s3_q;
    logic [rbbs_pkg::IN_W-1:0] f_q;
    logic [2:0]                phase_q;
    logic                      mc_tick;
    logic [4:0]                hold_q;
    logic                      rst_f;
    logic                      stb_f;
    logic                      stb_prev_q;
    logic                      stb_fall;
    logic                      hstb_prev_q;
    logic                      host_cmd;
    logic [2:0]                hcmd;
    logic [7:0]                tp_f;
    logic                      iap_en_q;
    logic [1:0]                sc_q;
    logic [1:0]                field_q;
    logic                      cfg_wr;
    logic                      cmd_wr;
    logic                      prog_lo;
    logic                      prog_hi;
    logic                      erase;
    logic                      pin_rst;
    logic                      strobe_d;

    assign in_w = {third_port_i, ext_fetch_sel_i, strobe_in_i, rst_pin_i};

    // three-stage sync
    // a new level counts only once stages two and three agree
    for (genvar i = 0; i < rbbs_pkg::IN_W; i++) begin : g_sync
        always_ff @(posedge clk_i) begin
            if (sys_rst_i) begin
                s1_q[i] <= rbbs_pkg::IN_IDLE[i];
                s2_q[i] <= rbbs_pkg::IN_IDLE[i];
                s3_q[i] <= rbbs_pkg::IN_IDLE[i];
                f_q[i]  <= rbbs_pkg::IN_IDLE[i];
            end else if (ce_i) begin
                s1_q[i] <= in_w[i];
                s2_q[i] <= s1_q[i];
                s3_q[i] <= s2_q[i];
                if (s2_q[i] == s3_q[i]) begin
                    f_q[i] <= s3_q[i];
                end
            end
        end
    end

    assign rst_f = f_q[rbbs_pkg::IX_RST];
    assign stb_f = f_q[rbbs_pkg::IX_STB];
    assign tp_f  = f_q[rbbs_pkg::IX_TP +: 8];
    assign pin_rst = core_rst_o;

    // machine cycle prescaler
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            phase_q <= 3'h0;
        end else if (ce_i) begin
            if (phase_q == rbbs_pkg::MC_LAST) begin
                phase_q <= 3'h0;
            end else begin
                phase_q <= phase_q + 3'h1;
            end
        end
    end

    assign mc_tick = (phase_q == rbbs_pkg::MC_LAST);

    // count machine cycles of reset high
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            hold_q <= 5'h00;
        end else if (ce_i) begin
            if (!rst_f) begin
                hold_q <= 5'h00;
            end else if (mc_tick && hold_q != rbbs_pkg::CNT_MAX) begin
                hold_q <= hold_q + 5'h01;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            core_rst_o <= 1'b0;
        end else if (ce_i) begin
            core_rst_o <= rst_f && (hold_q >= rbbs_pkg::RST_MC);
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            stb_prev_q  <= 1'b1;
            hstb_prev_q <= 1'b1;
        end else if (ce_i) begin
            stb_prev_q  <= stb_f;
            hstb_prev_q <= tp_f[rbbs_pkg::HOST_STB_BIT];
        end
    end

    assign stb_fall = stb_prev_q && !stb_f;

    // forced strobe fall with reset held long
    // a fresh reset without the fall drops host mode
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            host_mode_o <= 1'b0;
        end else if (ce_i) begin
            if (stb_fall && rst_f && hold_q > rbbs_pkg::HOST_MC) begin
                host_mode_o <= 1'b1;
            end else if (rst_f && hold_q == rbbs_pkg::RST_MC) begin
                host_mode_o <= 1'b0;
            end
        end
    end

    // fetch source, lock level 4 wins
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            ext_fetch_o <= 1'b0;
        end else if (ce_i) begin
            ext_fetch_o <= !f_q[rbbs_pkg::IX_EFS] && !sec_lvl4_i;
        end
    end

    // two strobes per cycle, second skipped on data access
    always_comb begin
        strobe_d = 1'b1;
        if (ext_fetch_o && !pin_rst && !host_mode_o) begin
            if (phase_q == rbbs_pkg::STB_PH_A) begin
                strobe_d = 1'b0;
            end else if (phase_q == rbbs_pkg::STB_PH_B) begin
                strobe_d = ext_data_cyc_i;
            end
        end
    end

    // pin released during reset and host mode so the host can force it
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            strobe_o    <= 1'b1;
            strobe_oe_o <= 1'b0;
        end else if (ce_i) begin
            strobe_o    <= strobe_d;
            strobe_oe_o <= !pin_rst && !host_mode_o;
        end
    end

    // host commands from the third port
    assign hcmd = tp_f[2:0];
    assign host_cmd = host_mode_o && tp_f[rbbs_pkg::HOST_STB_BIT]
                      && !hstb_prev_q;

    assign cfg_wr = bus_i.wr && bus_i.addr == rbbs_pkg::CFG_OFS;
    assign cmd_wr = bus_i.wr && bus_i.addr == rbbs_pkg::CMD_OFS
                    && iap_en_q;

    // only host or in-application commands program
    assign prog_lo = (host_cmd && hcmd == rbbs_pkg::HCMD_LO)
                     || (cmd_wr && bus_i.wdata[rbbs_pkg::CMD_PROG_LO]);
    assign prog_hi = (host_cmd && hcmd == rbbs_pkg::HCMD_HI)
                     || (cmd_wr && bus_i.wdata[rbbs_pkg::CMD_PROG_HI]);
    assign erase   = (host_cmd && hcmd == rbbs_pkg::HCMD_ERA)
                     || (cmd_wr && bus_i.wdata[rbbs_pkg::CMD_ERASE]);

    // programmed bit holds 0, erased bit holds 1
    // sys_rst stands for the erased state of the cell
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            sc_q <= rbbs_pkg::SC_UNPROG;
        end else if (ce_i) begin
            if (erase) begin
                sc_q <= rbbs_pkg::SC_UNPROG;
            end else begin
                if (prog_lo) begin
                    sc_q[0] <= 1'b0;
                end
                if (prog_hi) begin
                    sc_q[1] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            iap_en_q <= 1'b0;
        end else if (ce_i && cfg_wr) begin
            iap_en_q <= bus_i.wdata[rbbs_pkg::CFG_IAP_EN];
        end
    end

    // field reloads while any reset source is active
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            field_q <= rbbs_pkg::FIELD_RST;
        end else if (ce_i) begin
            if (rst_src_i.por || pin_rst) begin
                field_q <= ~sc_q;
            end else if (rst_src_i.wdt || rst_src_i.bod) begin
                field_q <= sc_q[1] ? {field_q[1], ~sc_q[0]} : ~sc_q;
            end else if (rst_src_i.sw) begin
                field_q <= {1'b1, ~sc_q[0]};
            // bit 0 only, startup bits untouched
            end else if (cfg_wr) begin
                field_q[0] <= bus_i.wdata[0];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            block_sel_o <= rbbs_pkg::FIELD_RST;
        end else if (ce_i) begin
            block_sel_o <= field_q;
        end
    end

    // read data stands one cycle only
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rdata_o <= rbbs_pkg::DATA_ZERO;
        end else if (ce_i) begin
            rdata_o <= rbbs_pkg::DATA_ZERO;
            if (bus_i.rd) begin
                case (bus_i.addr)
                    rbbs_pkg::CFG_OFS: begin
                        rdata_o <= {1'b0, iap_en_q, 4'h0, field_q};
                    end
                    rbbs_pkg::STAT_OFS: begin
                        rdata_o <= {3'h0, pin_rst, ext_fetch_o,
                                    host_mode_o, sc_q};
                    end
                    default: begin
                        rdata_o <= rbbs_pkg::DATA_ZERO;
                    end
                endcase
            end
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    reset_entry_a: assert property (
        ce_i && rst_f && hold_q == rbbs_pkg::RST_MC |=> core_rst_o)
        else $error("pin reset not applied");
    host_entry_a: assert property (
        ce_i && stb_fall && rst_f && hold_q > rbbs_pkg::HOST_MC
        |=> host_mode_o)
        else $error("host mode not entered");
    host_cause_a: assert property (
        $rose(host_mode_o) |-> $past(hold_q) > rbbs_pkg::HOST_MC)
        else $error("host mode without long reset");
    normal_exit_a: assert property (
        ce_i && !stb_fall && rst_f && hold_q == rbbs_pkg::RST_MC
        |=> !host_mode_o)
        else $error("host mode kept without strobe fall");
    fetch_sel_a: assert property (
        ce_i && !sec_lvl4_i |=> ext_fetch_o == !$past(f_q[rbbs_pkg::IX_EFS]))
        else $error("fetch select not followed");
    lock_four_a: assert property (
        ce_i && sec_lvl4_i |=> !ext_fetch_o)
        else $error("external fetch under lock");
    strobe_idle_a: assert property (
        ce_i && !ext_fetch_o |=> strobe_o)
        else $error("strobe active on internal fetch");
    sc_guard_a: assert property (
        !(ce_i && (prog_lo || prog_hi || erase)) |=> $stable(sc_q))
        else $error("startup bits changed without command");
    por_load_a: assert property (
        ce_i && rst_src_i.por |=> field_q == ~$past(sc_q))
        else $error("power-on field load wrong");
    sw_load_a: assert property (
        ce_i && rst_src_i.sw && !rst_src_i.por && !pin_rst
        && !rst_src_i.wdt && !rst_src_i.bod
        |=> field_q == {1'b1, ~$past(sc_q[0])})
        else $error("software reset field load wrong");
    wdt_keep_a: assert property (
        ce_i && rst_src_i.wdt && !rst_src_i.por && !pin_rst && sc_q[1]
        |=> field_q[1] == $past(field_q[1]))
        else $error("watchdog reset changed field bit 1");
    bit0_write_a: assert property (
        ce_i && cfg_wr && !rst_src_i.por && !pin_rst && !rst_src_i.wdt
        && !rst_src_i.bod && !rst_src_i.sw
        |=> field_q[0] == $past(bus_i.wdata[0]) ##1 block_sel_o == field_q)
        else $error("field bit 0 write lost");
endmodule

/* verif/rbbs_host_model.sv */
`timescale 1ns/1ps
module rbbs_host_model (
    // clock
    input  wire logic       clk_i,
    // pins toward the device
    output logic            rst_pin_o,
    output logic            stb_oe_o,
    output logic            stb_o,
    output logic            fetch_sel_o,
    output logic [7:0]      port_o
);
    initial begin
        rst_pin_o   = 1'b0;
        stb_oe_o    = 1'b0;
        stb_o       = 1'b1;
        fetch_sel_o = 1'b1;
        port_o      = 8'hff;
    end

    task automatic set_rst(input logic v);
        @(posedge clk_i);
        rst_pin_o <= v;
    endtask

    task automatic force_fall(input int n);
        @(posedge clk_i);
        stb_oe_o <= 1'b1;
        stb_o    <= 1'b0;
        repeat (n) @(posedge clk_i);
        stb_o    <= 1'b1;
        repeat (6) @(posedge clk_i);
        stb_oe_o <= 1'b0;
    endtask

    task automatic fetch(input logic v);
        @(posedge clk_i);
        fetch_sel_o <= v;
    endtask

    task automatic command(input logic [2:0] code);
        @(posedge clk_i);
        port_o <= {5'h0f, code};
        repeat (6) @(posedge clk_i);
        port_o[7] <= 1'b1;
        repeat (6) @(posedge clk_i);
        port_o <= 8'hff;
    endtask
endmodule

/* verif/tb_reset_boot_block_select.sv */
`timescale 1ns/1ps
module tb_reset_boot_block_select;
    logic                    clk_i          = 1'b0;
    logic                    sys_rst_i;
    logic                    ce_i;
    logic                    sec_lvl4_i;
    logic                    ext_data_cyc_i;
    rbbs_pkg::rbbs_rst_src_s rst_src_i;
    rbbs_pkg::rbbs_bus_s     bus_i;
    logic                    rst_pin, h_oe, h_stb, fsel, line;
    logic                    strobe_o, strobe_oe_o, core_rst_o;
    logic                    host_mode_o, ext_fetch_o;
    logic [7:0]              port, rdata_o;
    logic [1:0]              block_sel_o;
    int                      failures    = 0;
    int                      checks_done = 0;

    always #2 clk_i = ~clk_i;
    // strobe pin has a pull-up when nobody drives it
    assign line = strobe_oe_o ? strobe_o : (h_oe ? h_stb : 1'b1);

    rbbs_top DUT (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
        .rst_pin_i(rst_pin), .strobe_in_i(line), .strobe_o(strobe_o),
        .strobe_oe_o(strobe_oe_o), .ext_fetch_sel_i(fsel),
        .third_port_i(port), .rst_src_i(rst_src_i),
        .sec_lvl4_i(sec_lvl4_i), .ext_data_cyc_i(ext_data_cyc_i),
        .core_rst_o(core_rst_o), .host_mode_o(host_mode_o),
        .ext_fetch_o(ext_fetch_o), .block_sel_o(block_sel_o),
        .bus_i(bus_i), .rdata_o(rdata_o));
    rbbs_host_model PM (.clk_i(clk_i), .rst_pin_o(rst_pin), .stb_oe_o(h_oe),
        .stb_o(h_stb), .fetch_sel_o(fsel), .port_o(port));

    task automatic check(input string nm, input logic [7:0] seen,
                         input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk_i);
        bus_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_i);
        bus_i <= '0;
    endtask
    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge clk_i);
        bus_i <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_i);
        bus_i <= '0;
        #1 d = rdata_o;
    endtask
    task automatic count_low(input string nm, input logic [7:0] exp);
        int n = 0;
        repeat (24) begin
            @(posedge clk_i);
            #1 n += (strobe_o === 1'b0);
        end
        check(nm, n[7:0], exp);
    endtask

    task automatic t_reset();
        logic [7:0] d;
        settle(1);
        check("block_sel", block_sel_o, 8'h00);
        check("strobe idle", strobe_o, 8'h01);
        check("strobe driven", strobe_oe_o, 8'h01);
        rd(rbbs_pkg::STAT_OFS, d);
        check("status", d, 8'h03);
        $display("test reset done");
    endtask
    task automatic t_pin();
        int i;
        PM.set_rst(1'b1);
        repeat (4) @(posedge clk_i);
        PM.set_rst(1'b0);
        settle(20);
        check("short pulse", core_rst_o, 8'h00);
        PM.set_rst(1'b1);
        for (i = 0; i < 40 && core_rst_o !== 1'b1; i++) begin
            @(posedge clk_i);
            #1;
        end
        check("pin reset", core_rst_o, 8'h01);
        check("reset delay", i >= 6, 8'h01);
        settle(2);
        check("field pin reset", block_sel_o, 8'h00);
        check("strobe released", strobe_oe_o, 8'h00);
        PM.set_rst(1'b0);
        for (i = 0; i < 12 && core_rst_o !== 1'b0; i++) begin
            @(posedge clk_i);
            #1;
        end
        check("leave reset", core_rst_o, 8'h00);
        check("normal mode", host_mode_o, 8'h00);
        $display("test pin reset done");
    endtask
    task automatic t_strobe();
        PM.fetch(1'b0);
        settle(12);
        check("ext fetch", ext_fetch_o, 8'h01);
        count_low("two pulses", 8'h08);
        ext_data_cyc_i <= 1'b1;
        settle(6);
        count_low("skip pulse", 8'h04);
        PM.fetch(1'b1);
        settle(12);
        check("int fetch", ext_fetch_o, 8'h00);
        count_low("no pulse", 8'h00);
        PM.fetch(1'b0);
        sec_lvl4_i <= 1'b1;
        settle(12);
        check("locked fetch", ext_fetch_o, 8'h00);
        count_low("locked strobe", 8'h00);
        sec_lvl4_i     <= 1'b0;
        ext_data_cyc_i <= 1'b0;
        PM.fetch(1'b1);
        $display("test strobe done");
    endtask
    task automatic t_host();
        PM.set_rst(1'b1);
        settle(60);
        PM.force_fall(6);
        settle(4);
        check("early edge", host_mode_o, 8'h00);
        settle(100);
        PM.force_fall(6);
        check("host entry", host_mode_o, 8'h01);
        PM.set_rst(1'b0);
        settle(12);
        check("host kept", host_mode_o, 8'h01);
        $display("test host entry done");
    endtask
    task automatic set_sc(input logic [1:0] v);
        logic [7:0] d;
        PM.command(rbbs_pkg::HCMD_ERA);
        if (!v[0]) PM.command(rbbs_pkg::HCMD_LO);
        if (!v[1]) PM.command(rbbs_pkg::HCMD_HI);
        settle(2);
        rd(rbbs_pkg::STAT_OFS, d);
        check("startup bits", d[1:0], v);
    endtask
    task automatic src(input rbbs_pkg::rbbs_rst_src_s s,
                       input logic [1:0] exp, input string nm);
        @(posedge clk_i);
        rst_src_i <= s;
        @(posedge clk_i);
        rst_src_i <= '0;
        settle(2);
        check(nm, block_sel_o, exp);
    endtask
    task automatic t_field();
        logic [2:0] v;
        for (v = 0; v < 4; v++) begin
            set_sc(v[1:0]);
            src(4'h8, ~v[1:0], "por");
            src(4'h4, v[1] ? {1'b0, ~v[0]} : ~v[1:0], "wdt");
            src(4'h1, {1'b1, ~v[0]}, "soft");
            src(4'h2, v[1] ? {1'b1, ~v[0]} : ~v[1:0], "bod");
        end
        $display("test field load done");
    endtask
    task automatic t_regs();
        logic [7:0] d;
        wr(rbbs_pkg::CFG_OFS, 8'h00);
        settle(2);
        check("bit0 clear", block_sel_o, 8'h02);
        wr(rbbs_pkg::CMD_OFS, 8'h03);
        rd(rbbs_pkg::STAT_OFS, d);
        check("cmd refused", d[1:0], 8'h03);
        wr(rbbs_pkg::CFG_OFS, 8'h41);
        settle(2);
        check("bit0 set", block_sel_o, 8'h03);
        wr(rbbs_pkg::CMD_OFS, 8'h03);
        rd(rbbs_pkg::STAT_OFS, d);
        check("cmd program", d[1:0], 8'h00);
        wr(rbbs_pkg::CFG_OFS, 8'h40);
        settle(2);
        check("bit0 dynamic", block_sel_o, 8'h02);
        rd(rbbs_pkg::STAT_OFS, d);
        check("startup kept", d[1:0], 8'h00);
        rd(rbbs_pkg::CFG_OFS, d);
        check("cfg read", d, 8'h42);
        wr(rbbs_pkg::CMD_OFS, 8'h04);
        rd(rbbs_pkg::STAT_OFS, d);
        check("cmd erase", d[1:0], 8'h03);
        rd(2'h3, d);
        check("unmapped", d, 8'h00);
        $display("test registers done");
    endtask
    task automatic t_freeze();
        logic [7:0] d;
        ce_i <= 1'b0;
        wr(rbbs_pkg::CFG_OFS, 8'h41);
        settle(2);
        check("frozen field", block_sel_o, 8'h02);
        ce_i <= 1'b1;
        settle(2);
        check("write dropped", block_sel_o, 8'h02);
        sys_rst_i <= 1'b1;
        settle(2);
        sys_rst_i <= 1'b0;
        settle(1);
        check("rerun field", block_sel_o, 8'h00);
        check("rerun host", host_mode_o, 8'h00);
        check("rerun strobe oe", strobe_oe_o, 8'h01);
        rd(rbbs_pkg::STAT_OFS, d);
        check("rerun status", d, 8'h03);
        $display("test freeze and reset done");
    endtask

    task automatic tally_and_finish();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        sys_rst_i      = 1'b1;
        ce_i           = 1'b1;
        sec_lvl4_i     = 1'b0;
        ext_data_cyc_i = 1'b0;
        rst_src_i      = '0;
        bus_i          = '0;
        repeat (8) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        t_reset();
        t_pin();
        t_strobe();
        t_host();
        t_field();
        t_regs();
        t_freeze();
        tally_and_finish();
    end
    // the tests need under a thousand cycles; this is far beyond
    initial begin
        repeat (20000) @(posedge clk_i);
        failures++;
        tally_and_finish();
    end
endmodule
